/* rtl/irq_unit_map.svh */
// constants of the interrupt request unit
// assumes one 100 MHz clock and an 8-bit data-memory stack
`ifndef IRQ_UNIT_MAP_SVH
`define IRQ_UNIT_MAP_SVH

// number of request sources
`define NUM_SOURCES    7
// source bit positions in the request flag word
`define SRC_PORT_A     0
`define SRC_PORT_B     1
`define SRC_T16        2
`define SRC_COMPARATOR 3
`define SRC_SECOND_TIMER     4
`define SRC_THIRD_TIMER     5
`define SRC_PWM0       6
// edge selection codes
`define EDGE_BOTH      2'h0
`define EDGE_RISE      2'h1
`define EDGE_FALL      2'h2
// program flow
`define VECTOR_ADDR    16'h0010
`define SP_STEP        8'h02
`define SP_HI_OFS      8'h01
// reset values
`define FLAGS_RESET    7'h00
`define SP_RESET       8'h00
`define BYTE_ZERO      8'h00
`define WORD_ZERO      16'h0000

`endif

/* rtl/irq_unit_pkg.sv */
// types shared by the interrupt request unit files
// assumes irq_unit_map.svh for all numeric constants but the state codes
package irq_unit_pkg;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        st_idle    = 6'h01,
        st_push_hi = 6'h02,
        st_pop_lo  = 6'h04,
        st_pop_hi  = 6'h08,
        st_pop_end = 6'h10,
        st_spare   = 6'h20
    } seq_state_t;

    // state of the top-level unit
    typedef struct packed {
        seq_state_t  state;
        logic [6:0]  flags;
        logic        gie;
        logic [7:0]  stack_pointer;
        logic        mem_we;
        logic        mem_re;
        logic [7:0]  mem_addr;
        logic [7:0]  mem_wdata;
        logic [15:0] hold;
        logic [7:0]  low_byte;
        logic        op_irq;
        logic        op_reti;
        logic        pc_load;
        logic [15:0] pc_value;
        logic        af_load;
        logic [7:0]  accumulator;
        logic [7:0]  flag_reg;
        logic        taken;
        logic        done;
        logic        busy;
    } unit_state_t;

    // state of a pin synchroniser
    typedef struct packed {
        logic [2:0] stages;
        logic       level;
    } sync_state_t;

    // state of an edge detector
    typedef struct packed {
        logic prev;
    } edge_state_t;

endpackage

/* rtl/pin_synchroniser.sv */
// three-stage synchroniser for one asynchronous input
// assumes i_clk domain; output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pin_synchroniser (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // asynchronous level in, synchronised level out
    input  wire logic i_async,
    output var  logic o_level
);

    irq_unit_pkg::sync_state_t st;
    irq_unit_pkg::sync_state_t next_st;

    // shift chain; stage one feeds only stage two
    always_comb begin
        next_st = st;
        next_st.stages = {st.stages[1:0], i_async};
        if (st.stages[1] == st.stages[2]) begin
            next_st.level = st.stages[2];
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.level;

endmodule

`default_nettype wire

/* rtl/edge_flag_detector.sv */
// edge detector with selectable polarity for one request source
// assumes a level already in the i_clk domain
`timescale 1ns/100ps
`default_nettype none
`include "irq_unit_map.svh"

module edge_flag_detector (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // level and edge mode
    input  wire logic       i_level,
    input  wire logic [1:0] i_mode,
    // one-cycle event
    output var  logic       o_event
);

    irq_unit_pkg::edge_state_t st;
    irq_unit_pkg::edge_state_t next_st;
    logic                      rise;
    logic                      fall;

    // edge decode against the previous sample
    always_comb begin
        next_st      = st;
        next_st.prev = i_level;
        rise         = i_level & ~st.prev;
        fall         = ~i_level & st.prev;
        unique case (i_mode)
            `EDGE_RISE: o_event = rise;
            `EDGE_FALL: o_event = fall;
            default:    o_event = rise | fall; // both edges
        endcase
    end

    // state register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

`default_nettype wire

/* rtl/interrupt_request_unit.sv */
// interrupt request unit: flags, enables, entry and return sequencing
// assumes a cpu that offers instruction boundaries and holds off while busy,
// and a byte-wide data memory with one cycle of read latency
`timescale 1ns/100ps
`default_nettype none
`include "irq_unit_map.svh"

module interrupt_request_unit (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // request sources
    input  wire logic        i_port_a_bit_zero,
    input  wire logic        i_port_b_bit_zero,
    input  wire logic        i_comparator,
    input  wire logic [7:0]  i_t16_count_high,
    input  wire logic [2:0]  i_t16_bit_select,
    input  wire logic        i_second_timer,
    input  wire logic        i_third_timer,
    input  wire logic        i_first_pwm_generator,
    // configuration
    input  wire logic [11:0] i_edge_select,
    input  wire logic        i_t16_falling_edge,
    input  wire logic [6:0]  i_source_enable_reg,
    // software access
    input  wire logic        i_flag_write,
    input  wire logic [6:0]  i_flag_wdata,
    input  wire logic        i_global_enable_cmd,
    input  wire logic        i_global_disable_cmd,
    input  wire logic        i_sp_write,
    input  wire logic [7:0]  i_sp_wdata,
    // cpu sequencer
    input  wire logic        i_instr_boundary,
    input  wire logic [15:0] i_pc,
    input  wire logic        i_return,
    input  wire logic        i_save_af,
    input  wire logic        i_restore_af,
    input  wire logic [7:0]  i_accumulator,
    input  wire logic [7:0]  i_flag_reg,
    // stack memory
    output var  logic        o_mem_we,
    output var  logic        o_mem_re,
    output var  logic [7:0]  o_mem_addr,
    output var  logic [7:0]  o_mem_wdata,
    input  wire logic [7:0]  i_mem_rdata,
    // results to the cpu
    output var  logic [6:0]  o_request_flags,
    output var  logic        o_global_enable,
    output var  logic [7:0]  o_stack_pointer,
    output var  logic        o_pc_load,
    output var  logic [15:0] o_pc_value,
    output var  logic        o_af_load,
    output var  logic [7:0]  o_accumulator,
    output var  logic [7:0]  o_flag_reg,
    output var  logic        o_taken,
    output var  logic        o_done,
    output var  logic        o_busy
);

    irq_unit_pkg::unit_state_t st;
    irq_unit_pkg::unit_state_t next_st;
    logic [6:0]                src_level;
    logic [6:0]                edge_evt;
    logic [2:0]                pin_level;
    logic                      take;
    logic                      start_pop;

    // asynchronous sources pass the synchroniser
    pin_synchroniser u_sync_pa (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_port_a_bit_zero),
        .o_level  (pin_level[0])
    );
    pin_synchroniser u_sync_pb (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_port_b_bit_zero),
        .o_level  (pin_level[1])
    );
    pin_synchroniser u_sync_cmp (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_comparator),
        .o_level  (pin_level[2])
    );

    // source levels in flag-bit order
    always_comb begin
        src_level                  = '0;
        src_level[`SRC_PORT_A]     = pin_level[0];
        src_level[`SRC_PORT_B]     = pin_level[1];
        src_level[`SRC_T16]        = i_t16_count_high[i_t16_bit_select];
        src_level[`SRC_COMPARATOR] = pin_level[2];
        src_level[`SRC_SECOND_TIMER]     = i_second_timer;
        src_level[`SRC_THIRD_TIMER]     = i_third_timer;
        src_level[`SRC_PWM0]       = i_first_pwm_generator;
    end

    // one edge detector per source; the T16 slot has its own polarity bit
    genvar g;
    generate
        for (g = 0; g < `NUM_SOURCES; g++) begin : g_edge
            localparam int SEL = (g < `SRC_T16) ? g : g - 1;
            logic [1:0] mode;
            if (g == `SRC_T16) begin : g_t16
                assign mode = i_t16_falling_edge ? `EDGE_FALL : `EDGE_RISE;
            end else begin : g_other
                assign mode = i_edge_select[2*SEL +: 2];
            end
            edge_flag_detector u_edge (
                .i_clk    (i_clk),
                .i_resetn (i_resetn),
                .i_level  (src_level[g]),
                .i_mode   (mode),
                .o_event  (edge_evt[g])
            );
        end
    endgenerate

    // entry condition: enabled pending request at an instruction boundary
    assign take = (st.state == irq_unit_pkg::st_idle) & i_instr_boundary & st.gie
                & (|(st.flags & i_source_enable_reg));
    assign start_pop = (st.state == irq_unit_pkg::st_idle) & ~take & (i_return | i_restore_af);

    // next-state logic
    always_comb begin
        next_st         = st;
        next_st.mem_we  = 1'b0;
        next_st.pc_load = 1'b0;
        next_st.af_load = 1'b0;
        next_st.taken   = 1'b0;
        next_st.done    = 1'b0;
        // set wins over the software clear, enable plays no part
        next_st.flags = (i_flag_write ? (st.flags & i_flag_wdata) : st.flags) | edge_evt;
        if (i_global_enable_cmd) begin
            next_st.gie = 1'b1;
        end
        if (i_global_disable_cmd) begin
            next_st.gie = 1'b0;
        end
        unique case (st.state)
            irq_unit_pkg::st_idle: begin
                if (i_sp_write) begin
                    next_st.stack_pointer = i_sp_wdata;
                end
                if (take) begin
                    next_st.gie       = 1'b0;
                    next_st.op_irq    = 1'b1;
                    next_st.hold      = i_pc;
                    next_st.mem_we    = 1'b1;
                    next_st.mem_addr  = st.stack_pointer;
                    next_st.mem_wdata = i_pc[7:0];
                    next_st.taken     = 1'b1;
                    next_st.state     = irq_unit_pkg::st_push_hi;
                end else if (start_pop) begin
                    next_st.op_reti  = i_return;
                    next_st.mem_re   = 1'b1;
                    next_st.mem_addr = st.stack_pointer - `SP_STEP;
                    next_st.state    = irq_unit_pkg::st_pop_lo;
                end else if (i_save_af) begin
                    next_st.op_irq    = 1'b0;
                    next_st.hold      = {i_flag_reg, i_accumulator};
                    next_st.mem_we    = 1'b1;
                    next_st.mem_addr  = st.stack_pointer;
                    next_st.mem_wdata = i_accumulator;
                    next_st.state     = irq_unit_pkg::st_push_hi;
                end
            end
            irq_unit_pkg::st_push_hi: begin
                next_st.mem_we        = 1'b1;
                next_st.mem_addr      = st.stack_pointer + `SP_HI_OFS;
                next_st.mem_wdata     = st.hold[15:8];
                next_st.stack_pointer = st.stack_pointer + `SP_STEP;
                next_st.pc_load       = st.op_irq;
                next_st.pc_value      = `VECTOR_ADDR;
                next_st.done          = 1'b1;
                next_st.state         = irq_unit_pkg::st_idle;
            end
            irq_unit_pkg::st_pop_lo: begin
                // second read address; the low byte arrives on the next cycle
                next_st.mem_addr = st.stack_pointer - `SP_HI_OFS;
                next_st.state    = irq_unit_pkg::st_pop_hi;
            end
            irq_unit_pkg::st_pop_hi: begin
                next_st.low_byte = i_mem_rdata;
                next_st.mem_re   = 1'b0;
                next_st.state    = irq_unit_pkg::st_pop_end;
            end
            irq_unit_pkg::st_pop_end: begin
                next_st.stack_pointer = st.stack_pointer - `SP_STEP;
                next_st.done          = 1'b1;
                if (st.op_reti) begin
                    next_st.pc_load  = 1'b1;
                    next_st.pc_value = {i_mem_rdata, st.low_byte};
                    next_st.gie      = 1'b1;
                end else begin
                    next_st.af_load     = 1'b1;
                    next_st.accumulator = st.low_byte;
                    next_st.flag_reg    = i_mem_rdata;
                end
                next_st.state = irq_unit_pkg::st_idle;
            end
            default: begin
                next_st.mem_re = 1'b0;
                next_st.state  = irq_unit_pkg::st_idle;
            end
        endcase
        next_st.busy = (next_st.state != irq_unit_pkg::st_idle);
    end

    // state register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st               <= '0;
            st.state         <= irq_unit_pkg::st_idle;
            st.flags         <= `FLAGS_RESET;
            st.stack_pointer <= `SP_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign o_mem_we        = st.mem_we;
    assign o_mem_re        = st.mem_re;
    assign o_mem_addr      = st.mem_addr;
    assign o_mem_wdata     = st.mem_wdata;
    assign o_request_flags = st.flags;
    assign o_global_enable = st.gie;
    assign o_stack_pointer = st.stack_pointer;
    assign o_pc_load       = st.pc_load;
    assign o_pc_value      = st.pc_value;
    assign o_af_load       = st.af_load;
    assign o_accumulator   = st.accumulator;
    assign o_flag_reg      = st.flag_reg;
    assign o_taken         = st.taken;
    assign o_done          = st.done;
    assign o_busy          = st.busy;

    // checks on flags and sequencing
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    property p_flag_set;
        (|edge_evt) |=> ((st.flags & $past(edge_evt)) == $past(edge_evt));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

    property p_no_soft_set;
        ((st.flags & ~$past(st.flags)) & ~$past(edge_evt)) == 7'h00;
    endproperty
    a_no_soft_set: assert property (p_no_soft_set) else $error("flag set without event");

    property p_flag_clear;
        i_flag_write |=> ((o_request_flags & ~$past(i_flag_wdata)) & ~$past(edge_evt)) == 7'h00;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag write did not clear");

    property p_take_gate;
        o_taken |-> ($past(o_global_enable) && $past(i_instr_boundary)
            && (|($past(o_request_flags) & $past(i_source_enable_reg))));
    endproperty
    a_take_gate: assert property (p_take_gate) else $error("entry without enabled request");

    property p_entry_write;
        take |=> (o_mem_we && o_mem_addr == $past(st.stack_pointer) && o_mem_wdata == $past(i_pc[7:0]))
            ##1 (o_mem_we && o_mem_addr == 8'($past(st.stack_pointer, 2) + `SP_HI_OFS)
            && o_mem_wdata == $past(i_pc[15:8], 2));
    endproperty
    a_entry_write: assert property (p_entry_write) else $error("program counter not pushed");

    property p_entry_sp;
        take |-> ##2 (o_stack_pointer == 8'($past(st.stack_pointer, 2) + `SP_STEP));
    endproperty
    a_entry_sp: assert property (p_entry_sp) else $error("stack pointer not raised by two");

    property p_entry_gie;
        take |=> !o_global_enable [*2];
    endproperty
    a_entry_gie: assert property (p_entry_gie) else $error("global enable kept on entry");

    property p_vector;
        take |-> ##2 (o_pc_load && o_pc_value == `VECTOR_ADDR);
    endproperty
    a_vector: assert property (p_vector) else $error("no jump to vector");

    property p_return;
        (start_pop && i_return) |-> ##4 (o_pc_load && o_global_enable
            && o_stack_pointer == 8'($past(st.stack_pointer, 4) - `SP_STEP));
    endproperty
    a_return: assert property (p_return) else $error("return sequence wrong");

    property p_return_addr;
        (start_pop) |=> (o_mem_re && o_mem_addr == 8'($past(st.stack_pointer) - `SP_STEP));
    endproperty
    a_return_addr: assert property (p_return_addr) else $error("pop address wrong");

    property p_restore;
        (start_pop && i_restore_af && !i_return) |-> ##4 (o_af_load && !o_pc_load
            && o_accumulator == $past(i_mem_rdata, 2) && o_flag_reg == $past(i_mem_rdata));
    endproperty
    a_restore: assert property (p_restore) else $error("restore data wrong");

    property p_t16_bit;
        (edge_evt[`SRC_T16]) |=> o_request_flags[`SRC_T16];
    endproperty
    a_t16_bit: assert property (p_t16_bit) else $error("timer request not in its bit");

    c_entry: cover property (take ##2 o_pc_load);
    c_disabled_flag: cover property ((|(edge_evt & ~i_source_enable_reg)) ##1 (|o_request_flags));
    c_return: cover property ((start_pop && i_return) ##4 o_pc_load);
    c_save_restore: cover property (o_af_load);
    c_flag_clear: cover property (i_flag_write ##1 (o_request_flags == 7'h00));

endmodule

`default_nettype wire

/* testbench/stack_memory_model.sv */
// partner model: byte-wide stack memory behind the unit's stack port
// assumes one clock; read data follows the address by one cycle
`timescale 1ns/100ps
`default_nettype none

module stack_memory_model (
    // clock
    input  wire logic       i_clk,
    // stack port from the unit
    input  wire logic       i_we,
    input  wire logic       i_re,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    // read data back to the unit
    output var  logic [7:0] o_rdata
);
    logic [7:0] mem [256];

    initial begin
        o_rdata = 8'h00;
    end

    // write a byte; read one cycle late, idle data toggles so stale bytes never match
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        if (i_re) begin
            o_rdata <= mem[i_addr];
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule

`default_nettype wire

/* testbench/interrupt_request_unit_tb.sv */
// testbench: sources, enables, entry, save, restore and return
// assumes the unit, its package and the stack memory model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "irq_unit_map.svh"

module interrupt_request_unit_tb;
    logic        i_clk, i_resetn, t16_fall, flag_wr, gie_on, gie_off, sp_wr, boundary, ret, save_af, rest_af;
    logic [6:0]  src, enables, flag_wd;
    logic [7:0]  t16_count, sp_wd, acc, fr;
    logic [2:0]  t16_sel;
    logic [11:0] edge_sel;
    logic [15:0] pc, pc_seen;
    logic [7:0]  acc_seen, fr_seen;
    wire logic        mem_we, mem_re, gie, pc_load, af_load, taken, done, busy;
    wire logic [7:0]  mem_addr, mem_wdata, mem_rdata, sp, acc_out, fr_out;
    wire logic [6:0]  flags;
    wire logic [15:0] pc_val;
    int err_total, compares, done_cnt, taken_cnt, m_flags, m_gie, m_sp, seed = 4;
    int stk[$];
    int ids[6] = '{0, 1, 3, 4, 5, 6};

    interrupt_request_unit dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_port_a_bit_zero(src[0]),
        .i_port_b_bit_zero(src[1]), .i_comparator(src[3]), .i_t16_count_high(t16_count),
        .i_t16_bit_select(t16_sel), .i_second_timer(src[4]), .i_third_timer(src[5]),
        .i_first_pwm_generator(src[6]), .i_edge_select(edge_sel), .i_t16_falling_edge(t16_fall),
        .i_source_enable_reg(enables), .i_flag_write(flag_wr), .i_flag_wdata(flag_wd),
        .i_global_enable_cmd(gie_on), .i_global_disable_cmd(gie_off), .i_sp_write(sp_wr),
        .i_sp_wdata(sp_wd), .i_instr_boundary(boundary), .i_pc(pc), .i_return(ret),
        .i_save_af(save_af), .i_restore_af(rest_af), .i_accumulator(acc), .i_flag_reg(fr),
        .o_mem_we(mem_we), .o_mem_re(mem_re), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
        .i_mem_rdata(mem_rdata), .o_request_flags(flags), .o_global_enable(gie),
        .o_stack_pointer(sp), .o_pc_load(pc_load), .o_pc_value(pc_val), .o_af_load(af_load),
        .o_accumulator(acc_out), .o_flag_reg(fr_out), .o_taken(taken), .o_done(done), .o_busy(busy));

    stack_memory_model stack_mem (.i_clk(i_clk), .i_we(mem_we), .i_re(mem_re), .i_addr(mem_addr),
        .i_wdata(mem_wdata), .o_rdata(mem_rdata));

    // clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // catch one-cycle result pulses
    always @(posedge i_clk) begin
        if (done === 1'b1) done_cnt++;
        if (taken === 1'b1) taken_cnt++;
        if (pc_load === 1'b1) pc_seen = pc_val;
        if (af_load === 1'b1) {acc_seen, fr_seen} = {acc_out, fr_out};
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // bounded wait until the flag word matches the model
    task automatic wait_flags(input int pre);
        int i;
        tick(pre);
        i = 0;
        while (i < 10 && flags !== m_flags[6:0]) begin
            tick(1);
            i++;
        end
        check("flags", 16'(m_flags), {9'h000, flags});
    endtask

    // clear one flag only, leave the others alone
    task automatic clear(input int idx);
        flag_wr = 1'b1;
        flag_wd = 7'h7f ^ (7'h01 << idx);
        tick(1);
        flag_wr = 1'b0;
        m_flags &= ~(1 << idx);
        wait_flags(0);
    endtask

    task automatic wait_done();
        int i, s;
        s = done_cnt;
        i = 0;
        while (done_cnt == s && i < 20) begin
            tick(1);
            i++;
        end
        check("done", 16'h0001, {15'h0000, done_cnt != s});
    endtask

    task automatic set_gie(input logic on);
        gie_on = on;
        gie_off = ~on;
        tick(1);
        {gie_on, gie_off} = 2'b00;
        m_gie = on;
        tick(1);
        check("gie", 16'(m_gie), {15'h0000, gie});
    endtask

    task automatic finish_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    initial begin
        {t16_fall, flag_wr, gie_on, gie_off, sp_wr, boundary, ret, save_af, rest_af} = '0;
        {src, enables, flag_wd, t16_count, sp_wd, acc, fr, t16_sel, pc} = '0;
        edge_sel = 12'h555;
        i_resetn = 1'b0;
        tick(4);
        i_resetn = 1'b1;
        tick(1);
        check("sp", 16'h0000, {8'h00, sp});
        wait_flags(0);
        $display("test reset finished");
        // every source but the sixteen_bit_timer raises its own flag, enables all off
        foreach (ids[k]) begin
            src[ids[k]] = 1'b1;
            m_flags |= 1 << ids[k];
            wait_flags(0);
            src[ids[k]] = 1'b0;
            wait_flags(8);
            clear(ids[k]);
        end
        $display("test sources finished");
        // edge modes on the second timer
        for (int mode = 0; mode < 4; mode++) begin
            edge_sel[7:6] = 2'(mode);
            tick(1);
            src[4] = 1'b1;
            if (mode != 2) m_flags |= 16;
            wait_flags(8);
            clear(4);
            src[4] = 1'b0;
            if (mode != 1) m_flags |= 16;
            wait_flags(8);
            clear(4);
        end
        $display("test edge modes finished");
        // sixteen_bit_timer bit select and polarity
        for (int s = 0; s < 8; s++) begin
            t16_sel = 3'(s);
            t16_fall = 1'b0;
            t16_count = 8'hff ^ (8'h01 << s);
            wait_flags(8);
            t16_count = 8'hff;
            m_flags |= 4;
            wait_flags(0);
            clear(2);
            t16_fall = 1'b1;
            tick(1);
            t16_count = 8'h00;
            m_flags |= 4;
            wait_flags(0);
            clear(2);
        end
        $display("test sixteen_bit_timer finished");
        // gating: own enable, global enable, instruction boundary
        sp_wr = 1'b1;
        sp_wd = 8'h10;
        tick(1);
        sp_wr = 1'b0;
        m_sp = 16;
        src[4] = 1'b1;
        m_flags |= 16;
        wait_flags(0);
        enables = 7'h6f;
        set_gie(1'b1);
        boundary = 1'b1;
        tick(1);
        boundary = 1'b0;
        tick(6);
        check("taken", 16'h0000, 16'(taken_cnt));
        enables = 7'h10;
        set_gie(1'b0);
        boundary = 1'b1;
        tick(1);
        boundary = 1'b0;
        tick(6);
        check("taken", 16'h0000, 16'(taken_cnt));
        set_gie(1'b1);
        tick(6);
        check("taken", 16'h0000, 16'(taken_cnt));
        $display("test gating finished");
        // entry
        pc = 16'($random(seed));
        boundary = 1'b1;
        tick(1);
        boundary = 1'b0;
        check("busy", 16'h0001, {15'h0000, busy});
        wait_done();
        stk.push_back(pc);
        check("busy", 16'h0000, {15'h0000, busy});
        m_sp += `SP_STEP;
        check("taken", 16'h0001, 16'(taken_cnt));
        check("stack_lo", {8'h00, pc[7:0]}, {8'h00, stack_mem.mem[m_sp - 2]});
        check("stack_hi", {8'h00, pc[15:8]}, {8'h00, stack_mem.mem[m_sp - 1]});
        check("sp", 16'(m_sp), {8'h00, sp});
        check("gie", 16'h0000, {15'h0000, gie});
        check("vector", `VECTOR_ADDR, pc_seen);
        $display("test entry finished");
        // save and restore inside the service routine
        {acc, fr} = 16'($random(seed));
        save_af = 1'b1;
        tick(1);
        save_af = 1'b0;
        wait_done();
        m_sp += 2;
        check("save_acc", {8'h00, acc}, {8'h00, stack_mem.mem[m_sp - 2]});
        check("save_flag", {8'h00, fr}, {8'h00, stack_mem.mem[m_sp - 1]});
        wait_flags(0);
        clear(4);
        rest_af = 1'b1;
        tick(1);
        rest_af = 1'b0;
        wait_done();
        m_sp -= 2;
        check("restore", {acc, fr}, {acc_seen, fr_seen});
        check("sp", 16'(m_sp), {8'h00, sp});
        $display("test save restore finished");
        // return
        ret = 1'b1;
        tick(1);
        ret = 1'b0;
        wait_done();
        m_sp -= 2;
        check("return_pc", 16'(stk.pop_back()), pc_seen);
        check("sp", 16'(m_sp), {8'h00, sp});
        check("gie", 16'h0001, {15'h0000, gie});
        $display("test return finished");
        finish_test();
    end
endmodule

`default_nettype wire
